// >>> design/acec_consts.svh
// register map, field layout, reset values and sizes of the comparator control
`ifndef ACEC_CONSTS_SVH
`define ACEC_CONSTS_SVH

`define ACEC_NUM_COMP        3
`define ACEC_ADDR_W          8
`define ACEC_DATA_W          32

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ACEC_CFG0_OFF        8'h00
`define ACEC_CFG_STRIDE      8'h04
`define ACEC_REF_OFF         8'h10
`define ACEC_INT_EN_OFF      8'h14
`define ACEC_RAW_STAT_OFF    8'h18
`define ACEC_MASK_STAT_OFF   8'h1c
`define ACEC_INT_CLR_OFF     8'h20
`define ACEC_VALUE_OFF       8'h24

// ----------------------------------------------------------------------------
// per-comparator configuration fields
// ----------------------------------------------------------------------------
`define ACEC_CFG_W           14
`define ACEC_CFG_TRIG_LSB    0
`define ACEC_CFG_INT_LSB     4
`define ACEC_CFG_SRC_LSB     8
`define ACEC_CFG_OUT_EN_BIT  12
`define ACEC_CFG_OUT_INV_BIT 13
`define ACEC_CFG_WR_MASK     14'h3777
`define ACEC_CFG_RST         14'h0000

// ----------------------------------------------------------------------------
// internal reference code: 0 off, 1..28 levels from 0 V upward
// ----------------------------------------------------------------------------
`define ACEC_REF_W           5
`define ACEC_REF_OFF_CODE    5'h00
`define ACEC_REF_MAX_CODE    5'h1c
`define ACEC_REF_RST         5'h00

`define ACEC_INT_EN_RST      3'h0

`endif

// >>> design/acec_pkg.sv
// types shared by the comparator control modules
package acec_pkg;

    typedef enum logic [2:0] {
        ADC_TRIGGER_NEVER        = 3'h0,
        ADC_TRIGGER_LEVEL_HIGH   = 3'h1,
        ADC_TRIGGER_LEVEL_LOW    = 3'h2,
        ADC_TRIGGER_FALLING_EDGE = 3'h3,
        ADC_TRIGGER_RISING_EDGE  = 3'h4,
        ADC_TRIGGER_ANY_EDGE     = 3'h5
    } acec_trig_t;

    typedef enum logic [2:0] {
        INT_LEVEL_HIGH   = 3'h0,
        INT_LEVEL_LOW    = 3'h1,
        INT_FALLING_EDGE = 3'h2,
        INT_RISING_EDGE  = 3'h3,
        INT_ANY_EDGE     = 3'h4
    } acec_int_t;

    typedef enum logic [1:0] {
        REFERENCE_OWN_PIN        = 2'h0,
        REFERENCE_FIRST_UNIT_PIN = 2'h1,
        REFERENCE_INTERNAL_LEVEL = 2'h2
    } acec_ref_src_t;

endpackage

// >>> design/acec_sync.sv
// two-stage synchroniser for the comparator outputs
`timescale 1ns/1ps
`default_nettype none

module acec_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage1_d;
    logic [WIDTH-1:0] stage2_d;

    always_comb begin
        stage1_d = asyncIn;
        stage2_d = stage1_q;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= stage1_d;
            stage2_q <= stage2_d;
        end
    end

    assign syncOut = stage2_q;

endmodule

`default_nettype wire

// >>> design/acec_unit.sv
// edge detection and trigger / interrupt conditions of one comparator
`timescale 1ns/1ps
`default_nettype none

module acec_unit (
    input  wire logic               clock,
    input  wire logic               rst_b,
    input  wire logic               compLevel,
    input  wire logic [2:0]         trigSel,
    input  wire logic [2:0]         intSel,
    output logic                    trigHit,
    output logic                    intHit
);

    logic prev_q;
    logic prev_d;
    logic primed_q;
    logic primed_d;
    logic rise;
    logic fall;

    // --------------------------------------------------------------------
    // previous sample; no edge reported before the first real sample
    // --------------------------------------------------------------------
    always_comb begin
        prev_d   = compLevel;
        primed_d = 1'b1;
        rise     = primed_q & compLevel & ~prev_q;
        fall     = primed_q & ~compLevel & prev_q;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prev_q   <= 1'b0;
            primed_q <= 1'b0;
        end else begin
            prev_q   <= prev_d;
            primed_q <= primed_d;
        end
    end

    // --------------------------------------------------------------------
    // conditions, each chosen on its own select
    // --------------------------------------------------------------------
    always_comb begin
        case (acec_pkg::acec_trig_t'(trigSel))
            acec_pkg::ADC_TRIGGER_LEVEL_HIGH:   trigHit = compLevel;
            acec_pkg::ADC_TRIGGER_LEVEL_LOW:    trigHit = ~compLevel;
            acec_pkg::ADC_TRIGGER_FALLING_EDGE: trigHit = fall;
            acec_pkg::ADC_TRIGGER_RISING_EDGE:  trigHit = rise;
            acec_pkg::ADC_TRIGGER_ANY_EDGE:     trigHit = rise | fall;
            default:                            trigHit = 1'b0;
        endcase
        case (acec_pkg::acec_int_t'(intSel))
            acec_pkg::INT_LEVEL_HIGH:   intHit = compLevel;
            acec_pkg::INT_LEVEL_LOW:    intHit = ~compLevel;
            acec_pkg::INT_FALLING_EDGE: intHit = fall;
            acec_pkg::INT_RISING_EDGE:  intHit = rise;
            acec_pkg::INT_ANY_EDGE:     intHit = rise | fall;
            default:                    intHit = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// >>> design/acec_top.sv
// register file, interrupt and pin logic of the analog comparator bank
`timescale 1ns/1ps
`default_nettype none
`include "acec_consts.svh"

// Functional notes
// - reference source: own pin, unit 0 pin, internal
// - ADC trigger: never, high, low, fall, rise, both
// - interrupt: high, low, fall, rise, both
// - trigger and interrupt conditions chosen independently
// - optional pin output, plain or inverted
// - clear drops pending; held level re-asserts
// - interrupt enable gates path to processor
// - raw and masked interrupt status readable
// - present comparator output level readable
// - internal reference code: off or level
module acec_top (
    input  wire logic                          clock,
    input  wire logic                          rst_b,
    input  wire logic [`ACEC_ADDR_W-1:0]       addr,
    input  wire logic [`ACEC_DATA_W-1:0]       wrData,
    input  wire logic                          wrStb,
    input  wire logic                          rdStb,
    output logic      [`ACEC_DATA_W-1:0]       rdData,
    input  wire logic [`ACEC_NUM_COMP-1:0]     compRaw,
    output logic      [`ACEC_NUM_COMP-1:0]     adcTrigger,
    output logic      [`ACEC_NUM_COMP-1:0]     compPin,
    output logic      [`ACEC_NUM_COMP-1:0]     compPinEn,
    output logic      [2*`ACEC_NUM_COMP-1:0]   refSourceSel,
    output logic      [`ACEC_REF_W-1:0]        refLevelCode,
    output logic                               irq
);

    localparam int N = `ACEC_NUM_COMP;

    logic [`ACEC_CFG_W-1:0]  cfg_q [N];
    logic [`ACEC_CFG_W-1:0]  cfg_d [N];
    logic [`ACEC_REF_W-1:0]  refCode_q;
    logic [`ACEC_REF_W-1:0]  refCode_d;
    logic [N-1:0]            intEn_q;
    logic [N-1:0]            intEn_d;
    logic [N-1:0]            rawStat_q;
    logic [N-1:0]            rawStat_d;
    logic [`ACEC_DATA_W-1:0] rdData_q;
    logic [`ACEC_DATA_W-1:0] rdData_d;
    logic [N-1:0]            adcTrig_q;
    logic [N-1:0]            adcTrig_d;
    logic [N-1:0]            pin_q;
    logic [N-1:0]            pin_d;
    logic [N-1:0]            pinEn_q;
    logic [N-1:0]            pinEn_d;
    logic                    irq_q;
    logic                    irq_d;

    logic [N-1:0]            compLevel;
    logic [N-1:0]            trigHit;
    logic [N-1:0]            intHit;
    logic [N-1:0]            statClr;
    logic [2*N-1:0]          srcSel;

    // ------------------------------------------------------------------------
    // comparator outputs into the clock domain
    // ------------------------------------------------------------------------
    acec_sync #(
        .WIDTH   (N)
    ) u_sync (
        .clock   (clock),
        .rst_b   (rst_b),
        .asyncIn (compRaw),
        .syncOut (compLevel)
    );

    // ------------------------------------------------------------------------
    // per-comparator condition logic
    // ------------------------------------------------------------------------
    for (genvar g = 0; g < N; g++) begin : g_unit
        acec_unit u_unit (
            .clock     (clock),
            .rst_b     (rst_b),
            .compLevel (compLevel[g]),
            .trigSel   (cfg_q[g][`ACEC_CFG_TRIG_LSB +: 3]),
            .intSel    (cfg_q[g][`ACEC_CFG_INT_LSB +: 3]),
            .trigHit   (trigHit[g]),
            .intHit    (intHit[g])
        );
    end

    // ------------------------------------------------------------------------
    // register writes, status clear and read mux
    // ------------------------------------------------------------------------
    always_comb begin
        cfg_d     = cfg_q;
        refCode_d = refCode_q;
        intEn_d   = intEn_q;
        statClr   = '0;
        rdData_d  = '0;
        for (int i = 0; i < N; i++) begin
            if (wrStb && addr == 8'(`ACEC_CFG0_OFF + `ACEC_CFG_STRIDE * i)) begin
                cfg_d[i] = wrData[`ACEC_CFG_W-1:0] & `ACEC_CFG_WR_MASK;
            end
        end
        if (wrStb && addr == `ACEC_REF_OFF &&
            wrData[`ACEC_REF_W-1:0] <= `ACEC_REF_MAX_CODE) begin
            refCode_d = wrData[`ACEC_REF_W-1:0];
        end
        if (wrStb && addr == `ACEC_INT_EN_OFF) begin
            intEn_d = wrData[N-1:0];
        end
        if (wrStb && addr == `ACEC_INT_CLR_OFF) begin
            statClr = wrData[N-1:0];
        end
        if (rdStb && addr == `ACEC_RAW_STAT_OFF) begin
            statClr = '1;
        end
        if (rdStb) begin
            for (int i = 0; i < N; i++) begin
                if (addr == 8'(`ACEC_CFG0_OFF + `ACEC_CFG_STRIDE * i)) begin
                    rdData_d[`ACEC_CFG_W-1:0] = cfg_q[i];
                end
            end
            case (addr)
                `ACEC_REF_OFF: begin
                    rdData_d[`ACEC_REF_W-1:0] = refCode_q;
                end
                `ACEC_INT_EN_OFF: begin
                    rdData_d[N-1:0] = intEn_q;
                end
                `ACEC_RAW_STAT_OFF: begin
                    rdData_d[N-1:0] = rawStat_q;
                end
                `ACEC_MASK_STAT_OFF: begin
                    rdData_d[N-1:0] = rawStat_q & intEn_q;
                end
                `ACEC_VALUE_OFF: begin
                    rdData_d[N-1:0] = compLevel;
                end
                default: begin
                    rdData_d = rdData_d;
                end
            endcase
        end
        // set wins over clear: a held level re-asserts at once
        rawStat_d = (rawStat_q & ~statClr) | intHit;
    end

    // ------------------------------------------------------------------------
    // outputs toward pins, ADC sequencer and interrupt controller
    // ------------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < N; i++) begin
            pinEn_d[i] = cfg_q[i][`ACEC_CFG_OUT_EN_BIT];
            pin_d[i]   = pinEn_d[i] &
                         (compLevel[i] ^ cfg_q[i][`ACEC_CFG_OUT_INV_BIT]);
            srcSel[2*i +: 2] = cfg_q[i][`ACEC_CFG_SRC_LSB +: 2];
        end
        adcTrig_d = trigHit;
        irq_d     = |(rawStat_d & intEn_d);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < N; i++) begin
                cfg_q[i] <= `ACEC_CFG_RST;
            end
            refCode_q <= `ACEC_REF_RST;
            intEn_q   <= `ACEC_INT_EN_RST;
            rawStat_q <= '0;
            rdData_q  <= '0;
            adcTrig_q <= '0;
            pin_q     <= '0;
            pinEn_q   <= '0;
            irq_q     <= 1'b0;
        end else begin
            cfg_q     <= cfg_d;
            refCode_q <= refCode_d;
            intEn_q   <= intEn_d;
            rawStat_q <= rawStat_d;
            rdData_q  <= rdData_d;
            adcTrig_q <= adcTrig_d;
            pin_q     <= pin_d;
            pinEn_q   <= pinEn_d;
            irq_q     <= irq_d;
        end
    end

    assign rdData       = rdData_q;
    assign adcTrigger   = adcTrig_q;
    assign compPin      = pin_q;
    assign compPinEn    = pinEn_q;
    assign refLevelCode = refCode_q;
    assign irq          = irq_q;

    // source select drawn straight from the configuration flops
    assign refSourceSel = srcSel;

endmodule

`default_nettype wire

// >>> test/acec_comp_model.sv
// comparator front end model that drives the raw comparator outputs
`timescale 1ns/1ps
`default_nettype none

module acec_comp_model #(
    parameter int STEP_MV = 100
) (
    input  wire logic       clock,
    input  wire logic [5:0] refSourceSel,
    input  wire logic [4:0] refLevelCode,
    input  var  int         posMv [3],
    input  var  int         negMv [3],
    output logic      [2:0] compRaw
);
    int refMv;

    // reference off never lets an output go high
    always @(posedge clock) begin
        for (int i = 0; i < 3; i++) begin
            case (refSourceSel[2*i +: 2])
                2'h1:    refMv = negMv[0];
                2'h2:    refMv = (refLevelCode == 5'h00) ? 32'h7fffffff
                                 : (int'(refLevelCode) - 1) * STEP_MV;
                default: refMv = negMv[i];
            endcase
            compRaw[i] <= posMv[i] > refMv;
        end
    end
endmodule
`default_nettype wire

// >>> test/acec_top_asserts.sv
// port-level checker of the comparator control block
`timescale 1ns/1ps
`default_nettype none
`include "acec_consts.svh"

module acec_top_asserts (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wrData,
    input wire logic        wrStb,
    input wire logic        rdStb,
    input wire logic [31:0] rdData,
    input wire logic [2:0]  compRaw,
    input wire logic [2:0]  adcTrigger,
    input wire logic [2:0]  compPin,
    input wire logic [2:0]  compPinEn,
    input wire logic [5:0]  refSourceSel,
    input wire logic [4:0]  refLevelCode,
    input wire logic        irq
);
    logic [2:0] trigSel_q;
    logic [2:0] trigSel_d;

    // shadow of the unit 0 trigger selection
    always_comb begin
        trigSel_d = trigSel_q;
        if (wrStb && addr == `ACEC_CFG0_OFF)
            trigSel_d = wrData[2:0];
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            trigSel_q <= 3'h0;
        else
            trigSel_q <= trigSel_d;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_irq_masked_off: assert property (wrStb && addr == `ACEC_INT_EN_OFF
        && wrData[2:0] == 3'h0 |=> !irq) else $error("irq with enables off");
    a_pin_disabled: assert property ((compPin & ~compPinEn) == 3'h0)
        else $error("pin driven while disabled");
    a_ref_range: assert property (refLevelCode <= 5'h1c)
        else $error("reference code out of range");
    a_ref_write: assert property (wrStb && addr == `ACEC_REF_OFF
        && wrData[4:0] <= 5'h1c |=> refLevelCode == $past(wrData[4:0]))
        else $error("reference code not taken");
    a_src_write: assert property (wrStb && addr == `ACEC_CFG0_OFF
        |=> refSourceSel[1:0] == $past(wrData[9:8]))
        else $error("reference source not taken");
    a_trig_never: assert property (trigSel_q == 3'h0
        && $past(trigSel_q) == 3'h0 |-> !adcTrigger[0])
        else $error("trigger while set to never");
    a_trig_pulse: assert property (trigSel_q == 3'h4
        && $past(trigSel_q) == 3'h4 && adcTrigger[0] |=> !adcTrigger[0])
        else $error("edge trigger longer than one cycle");
    a_value_read: assert property (rdStb && addr == `ACEC_VALUE_OFF
        && compRaw == $past(compRaw) && compRaw == $past(compRaw, 2)
        |=> rdData[2:0] == $past(compRaw)) else $error("value read wrong");

    c_irq: cover property ($rose(irq));
    c_trig: cover property ($rose(adcTrigger[0]));
    c_pin: cover property (compPinEn[0] && compPin[0]);
endmodule

bind acec_top acec_top_asserts chk (.clock, .rst_b, .addr, .wrData, .wrStb,
    .rdStb, .rdData, .compRaw, .adcTrigger, .compPin, .compPinEn,
    .refSourceSel, .refLevelCode, .irq);
`default_nettype wire

// >>> test/tb_top.sv
// testbench of the comparator control block
`timescale 1ns/1ps
`default_nettype none
`include "acec_consts.svh"

module tb_top;
    logic        clock = 1'h0;
    logic        rst_b = 1'h0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wrData = 32'h0;
    logic        wrStb = 1'h0;
    logic        rdStb = 1'h0;
    logic [31:0] rdData, q;
    logic [2:0]  compRaw, adcTrigger, compPin, compPinEn;
    logic [5:0]  refSourceSel;
    logic [4:0]  refLevelCode;
    logic        irq;
    int          posMv [3] = '{0, 0, 0};
    int          negMv [3] = '{500, 2000, 2000};
    int          err_count = 0;
    int          samples_checked = 0;
    int          nTrig, nHigh, nAll;
    int          tExp [6];
    bit          counting = 0;
    logic [1:0]  srcTab [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
    logic [4:0]  codeTab [5] = '{5'h00, 5'h00, 5'h0a, 5'h0c, 5'h00};
    logic        valTab [5] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0};
    logic        r1 [6] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
    logic        r2 [6] = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};
    logic        r3 [6] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0};

    acec_top uut (.clock, .rst_b, .addr, .wrData, .wrStb, .rdStb, .rdData,
        .compRaw, .adcTrigger, .compPin, .compPinEn, .refSourceSel,
        .refLevelCode, .irq);
    acec_comp_model model (.clock, .refSourceSel, .refLevelCode, .posMv,
        .negMv, .compRaw);

    initial forever #20 clock = ~clock;

    always @(posedge clock) if (counting) begin
        nAll++;
        nTrig += adcTrigger[0];
        nHigh += compRaw[0];
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic waitc(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wrData <= d;
        wrStb <= 1'h1;
        @(posedge clock);
        wrStb <= 1'h0;
    endtask

    task automatic rd(logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rdStb <= 1'h1;
        @(posedge clock);
        rdStb <= 1'h0;
        #1 q = rdData;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        waitc(4000);
        err_count++;
        final_report();
    end

    initial begin
        waitc(16);
        rst_b <= 1'h1;
        for (int a = 0; a <= 'h28; a += 4) begin
            rd(a[7:0]);
            check("reset", q, 32'h0);
        end
        wr(`ACEC_REF_OFF, 32'h1c);
        wr(`ACEC_REF_OFF, 32'h1d);
        rd(`ACEC_REF_OFF);
        check("ref", q, 32'h1c);
        wr(8'h04, 32'hffffffff);
        rd(8'h04);
        check("cfg", q, 32'h3777);
        // unit 1 against each reference source
        posMv[1] = 1000;
        for (int k = 0; k < 5; k++) begin
            wr(8'h04, {22'h0, srcTab[k], 8'h00});
            wr(`ACEC_REF_OFF, {27'h0, codeTab[k]});
            waitc(6);
            check("src", refSourceSel[3:2], srcTab[k]);
            check("code", refLevelCode, codeTab[k]);
            rd(`ACEC_VALUE_OFF);
            check("value", q[1], valTab[k]);
        end
        // unit 0: trigger and interrupt modes side by side
        wr(`ACEC_INT_EN_OFF, 32'h1);
        for (int i = 0; i < 6; i++) begin
            wr(`ACEC_CFG0_OFF, {18'h0, i[0], 1'h1, 5'h0, i[2:0], 1'h0, i[2:0]});
            wr(`ACEC_INT_CLR_OFF, 32'h7);
            waitc(6);
            nTrig = 0;
            nHigh = 0;
            nAll = 0;
            counting = 1;
            posMv[0] = 1000;
            waitc(8);
            check("pin", compPin[0], !i[0]);
            check("pin en", compPinEn[0], 1'h1);
            rd(`ACEC_RAW_STAT_OFF);
            check("raw1", q, r1[i]);
            rd(`ACEC_RAW_STAT_OFF);
            check("raw2", q, r2[i]);
            posMv[0] = 0;
            waitc(8);
            check("irq", irq, r3[i]);
            rd(`ACEC_RAW_STAT_OFF);
            check("raw3", q, r3[i]);
            counting = 0;
            tExp = '{0, nHigh, nAll - nHigh, 1, 1, 2};
            check("trig", nTrig, tExp[i]);
        end
        wr(`ACEC_CFG0_OFF, 32'h30);
        wr(`ACEC_INT_EN_OFF, 32'h0);
        wr(`ACEC_INT_CLR_OFF, 32'h7);
        posMv[0] = 1000;
        waitc(8);
        check("irq off", irq, 1'h0);
        rd(`ACEC_MASK_STAT_OFF);
        check("masked", q, 32'h0);
        wr(`ACEC_INT_EN_OFF, 32'h1);
        rd(`ACEC_MASK_STAT_OFF);
        check("masked on", q, 32'h1);
        check("irq on", irq, 1'h1);
        rd(`ACEC_RAW_STAT_OFF);
        check("raw", q, 32'h1);
        final_report();
    end
endmodule
`default_nettype wire
